/* File: logic/power_quality_monitor.sv */
`timescale 1ns/10ps
`include "pq_monitor_cfg.svh"

// Notes on behaviour
// - Angle counters tick at 512 kHz
// - Three voltage pair angles stored separately
// - Current pair angles from current crossings
// - Per phase voltage to current angle
// - Low voltage: no crossing, angle held
// - 4-wire codes check rising voltage order
// - 4-wire: missing phase flags sequence error
// - 3-wire codes check C and A edges
// - Raise error after count consecutive faults
// - 3-wire: missing phase flags sequence error
// - Peak select bits choose monitored phases
// - Current peak is sample over 32
// - Phase bits mark phases reaching peak
// - Voltage peak likewise with phase bits
// - Reading a peak register clears it
// - Tamper detect mode enables the comparator; other blocks keep running
// - Tamper window lasts (N+4)/50 seconds
// - Tamper if N+1 peaks on a channel
// - Four bit level picks comparator threshold
// - Pin zero low clean, pin one low tamper
// - Partial missing crossings flag, total missing not
module power_quality_monitor
	import pq_monitor_pkg::*;
	// Line slot length in core cycles; a bench may shorten it
#(parameter int unsigned SLOT_CYCLES = `LINE_SLOT_CYCLES)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [2:0] volt_pos,
	input wire logic [2:0] volt_neg,
	input wire logic [2:0] volt_above_threshold,
	input wire logic [2:0] cur_pos,
	input wire logic [`SAMPLE_W-1:0] filtered_current_wave [3],
	input wire logic [`SAMPLE_W-1:0] filtered_voltage_wave [3],
	input wire logic sample_strobe,
	input wire logic [2:0] cur_over_level,
	input wire logic [2:0] voltage_connection_select,
	input wire logic [3:0] sequence_count,
	input wire logic sequence_fault_clear,
	input wire logic sequence_irq_enable,
	input wire logic [2:0] peak_phase_select,
	input wire logic current_peak_read,
	input wire logic voltage_peak_read,
	input wire logic [3:0] detect_line_count,
	input wire logic [3:0] peak_detect_level,
	input wire logic power_mode_pin_low,
	input wire logic power_mode_pin_high,
	output logic [`ANGLE_W-1:0] angle_volt_a_to_b,
	output logic [`ANGLE_W-1:0] angle_volt_b_to_c,
	output logic [`ANGLE_W-1:0] angle_volt_a_to_c,
	output logic [`ANGLE_W-1:0] angle_cur_a_to_b,
	output logic [`ANGLE_W-1:0] angle_cur_b_to_c,
	output logic [`ANGLE_W-1:0] angle_cur_a_to_c,
	output logic [`ANGLE_W-1:0] angle_phase_a_v_to_i,
	output logic [`ANGLE_W-1:0] angle_phase_b_v_to_i,
	output logic [`ANGLE_W-1:0] angle_phase_c_v_to_i,
	output logic sequence_fault_flag,
	output logic sequence_fault_irq_n,
	output logic [31:0] current_peak_capture,
	output logic [31:0] voltage_peak_capture,
	output logic [3:0] comparator_level,
	output logic comparator_enable,
	output logic interrupt_pin_zero_n,
	output logic interrupt_pin_one_n
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] pm_meta_r;
	logic [1:0] pm_sync_r;
	logic [2:0] cmp_meta_r;
	logic [2:0] cmp_sync_r;
	logic [2:0] cmp_prev_r;
	// Mode pins and comparator come from outside the clock domain
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			pm_meta_r <= 2'h0;
			pm_sync_r <= 2'h0;
			cmp_meta_r <= 3'h0;
			cmp_sync_r <= 3'h0;
			cmp_prev_r <= 3'h0;
		end else begin
			pm_meta_r <= {power_mode_pin_high, power_mode_pin_low};
			pm_sync_r <= pm_meta_r;
			cmp_meta_r <= cur_over_level;
			cmp_sync_r <= cmp_meta_r;
			cmp_prev_r <= cmp_sync_r;
		end
	end

	power_mode_t mode;
	// Pin pair decode: high,low
	always_comb begin
		case (pm_sync_r)
			2'b00: mode = normal_power_mode;
			2'b01: mode = tamper_measure_mode;
			2'b10: mode = tamper_detect_mode;
			default: mode = idle_power_mode;
		endcase
	end

	// ****************************************
	// Angle measurement
	// ****************************************
	logic [7:0] div_r;
	logic tick;
	assign tick = (div_r == 8'(`ANGLE_DIV - 1));
	// Divider gives the 512 kHz enable; 40 MHz is not an exact multiple
	always_ff @(posedge core_clk) begin
		if (!reset_n || tick) div_r <= 8'h00;
		else div_r <= div_r + 8'h01;
	end

	// Only rising crossings above threshold count as references
	logic [2:0] vzx;
	assign vzx = volt_pos & volt_above_threshold;
	logic [2:0] vzx_fall;
	assign vzx_fall = volt_neg & volt_above_threshold;

	// Start/stop pairs: v-v, i-i, v-i
	logic [8:0] start_ev;
	logic [8:0] stop_ev;
	assign start_ev = {vzx[2], vzx[1], vzx[0], cur_pos[0], cur_pos[1], cur_pos[0], vzx[0], vzx[1], vzx[0]};
	assign stop_ev = {cur_pos[2], cur_pos[1], cur_pos[0], cur_pos[2], cur_pos[2], cur_pos[1], vzx[2], vzx[2],
		vzx[1]};
	logic [`ANGLE_W-1:0] angle_r [9];
	genvar g;
	generate
		for (g = 0; g < 9; g++) begin : g_angle
			logic [`ANGLE_W-1:0] cnt_r;
			logic run_r;
			// Count ticks from start crossing, latch on stop crossing
			always_ff @(posedge core_clk) begin
				if (!reset_n) begin
					cnt_r <= '0;
					run_r <= 1'b0;
					angle_r[g] <= '0;
				end else if (start_ev[g]) begin
					cnt_r <= '0;
					run_r <= 1'b1;
				end else if (run_r && stop_ev[g]) begin
					angle_r[g] <= cnt_r;
					run_r <= 1'b0;
				end else if (run_r && tick) begin
					cnt_r <= cnt_r + 1'b1;
				end
			end
		end
	endgenerate
	// Registered copies keep outputs straight from flops
	always_ff @(posedge core_clk) begin
		angle_volt_a_to_b <= angle_r[0];
		angle_volt_b_to_c <= angle_r[1];
		angle_volt_a_to_c <= angle_r[2];
		angle_cur_a_to_b <= angle_r[3];
		angle_cur_b_to_c <= angle_r[4];
		angle_cur_a_to_c <= angle_r[5];
		angle_phase_a_v_to_i <= angle_r[6];
		angle_phase_b_v_to_i <= angle_r[7];
		angle_phase_c_v_to_i <= angle_r[8];
	end

	// ****************************************
	// Phase sequence check
	// ****************************************
	logic four_wire;
	logic three_wire;
	assign four_wire = voltage_connection_select inside {`VCON_4W_A, `VCON_4W_B, `VCON_4W_C};
	assign three_wire = voltage_connection_select inside {`VCON_3W_A, `VCON_3W_B};
	// Expected event order as a small ring: 4-wire A,B,C; 3-wire A+,C+,A-,C-
	logic [1:0] exp_r;
	logic [3:0] bad_r;
	logic seq_ev;
	logic seq_ok;
	logic [3:0] evs;
	always_comb begin
		evs = four_wire ? {1'b0, vzx[2], vzx[1], vzx[0]} :
			{vzx_fall[2], vzx_fall[0], vzx[2], vzx[0]};
		seq_ev = (four_wire || three_wire) && (evs != 4'h0);
		seq_ok = evs[exp_r] && ($countones(evs) == 1);
	end
	// A missing phase lets the next one arrive out of turn; a total loss gives no events
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			exp_r <= 2'h0;
			bad_r <= 4'h0;
		end else if (seq_ev) begin
			if (seq_ok) begin
				bad_r <= 4'h0;
				exp_r <= (four_wire && exp_r == 2'h2) ? 2'h0 : exp_r + 2'h1;
			end else begin
				bad_r <= (bad_r == 4'hF) ? bad_r : bad_r + 4'h1;
				exp_r <= (four_wire && exp_r == 2'h2) ? 2'h0 : exp_r + 2'h1;
			end
		end
	end
	logic seq_trip;
	assign seq_trip = seq_ev && !seq_ok && (sequence_count != 4'h0) &&
		(({1'b0, bad_r} + 5'h01) >= {1'b0, sequence_count});
	// Sticky flag; a new trip beats a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!reset_n) sequence_fault_flag <= 1'b0;
		else if (seq_trip) sequence_fault_flag <= 1'b1;
		else if (sequence_fault_clear) sequence_fault_flag <= 1'b0;
	end
	always_ff @(posedge core_clk) begin
		if (!reset_n) sequence_fault_irq_n <= 1'b1;
		else sequence_fault_irq_n <= !((sequence_fault_flag || seq_trip) && sequence_irq_enable);
	end

	// ****************************************
	// Peak detection
	// ****************************************
	logic [`PEAK_VAL_W-1:0] cur_scaled [3];
	logic [`PEAK_VAL_W-1:0] volt_scaled [3];
	generate
		for (g = 0; g < 3; g++) begin : g_scale
			assign cur_scaled[g] = `PEAK_VAL_W'(filtered_current_wave[g] >> `PEAK_SHIFT);
			assign volt_scaled[g] = `PEAK_VAL_W'(filtered_voltage_wave[g] >> `PEAK_SHIFT);
		end
	endgenerate

	// Merge the largest selected sample into a running peak and its phase bits
	function automatic logic [31:0] peak_merge(input logic [31:0] cur, input logic [`PEAK_VAL_W-1:0] s [3],
		input logic [2:0] sel);
		logic [`PEAK_VAL_W-1:0] best;
		logic [2:0] ph;
		best = cur[`PEAK_VAL_W-1:0];
		ph = cur[`PEAK_PH_LSB+2:`PEAK_PH_LSB];
		for (int k = 0; k < 3; k++) begin
			if (sel[k] && s[k] > best) begin
				best = s[k];
				ph = 3'h0;
			end
		end
		for (int k = 0; k < 3; k++) begin
			if (sel[k] && s[k] == best && best != '0) ph[k] = 1'b1;
		end
		peak_merge = {5'h00, ph, best};
	endfunction : peak_merge

	// Read clears; a sample arriving with the read restarts tracking from it
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			current_peak_capture <= 32'h0000_0000;
			voltage_peak_capture <= 32'h0000_0000;
		end else begin
			if (current_peak_read) current_peak_capture <= sample_strobe ?
				peak_merge(32'h0000_0000, cur_scaled, peak_phase_select) : 32'h0000_0000;
			else if (sample_strobe) current_peak_capture <=
				peak_merge(current_peak_capture, cur_scaled, peak_phase_select);
			if (voltage_peak_read) voltage_peak_capture <= sample_strobe ?
				peak_merge(32'h0000_0000, volt_scaled, peak_phase_select) : 32'h0000_0000;
			else if (sample_strobe) voltage_peak_capture <=
				peak_merge(voltage_peak_capture, volt_scaled, peak_phase_select);
		end
	end

	// ****************************************
	// Tamper detection
	// ****************************************
	tamper_state_t td_state_r;
	logic [21:0] slot_r;
	logic [3:0] lines_r;
	logic [3:0] n_r;
	logic [3:0] peaks_r [3];
	logic slot_end;
	assign slot_end = (slot_r == 22'(SLOT_CYCLES - 1));
	logic tamper_hit;
	assign tamper_hit = (peaks_r[0] > n_r) || (peaks_r[1] > n_r) || (peaks_r[2] > n_r);

	// Window state machine; restarts whenever the mode is re-entered
	always_ff @(posedge core_clk) begin
		if (!reset_n || mode != tamper_detect_mode) begin
			td_state_r <= td_idle;
			slot_r <= '0;
			lines_r <= 4'h0;
			n_r <= 4'h0;
		end else begin
			case (td_state_r)
				td_idle: begin
					n_r <= (detect_line_count > `LINE_MAX) ? `LINE_MAX : detect_line_count;
					td_state_r <= td_count;
				end
				td_count: begin
					slot_r <= slot_end ? '0 : slot_r + 22'h1;
					if (slot_end) begin
						lines_r <= lines_r + 4'h1;
						if (lines_r + 4'h1 == n_r + `LINE_BIAS) td_state_r <= td_done;
					end
				end
				td_done: td_state_r <= td_done;
				default: td_state_r <= td_idle;
			endcase
		end
	end

	// Comparator rising edges count peaks per channel; kept through done so the verdict sees them
	generate
		for (g = 0; g < 3; g++) begin : g_peaks
			always_ff @(posedge core_clk) begin
				if (!reset_n || td_state_r == td_idle) peaks_r[g] <= 4'h0;
				else if (td_state_r == td_count && cmp_sync_r[g] && !cmp_prev_r[g] && peaks_r[g] != 4'hF)
					peaks_r[g] <= peaks_r[g] + 4'h1;
			end
		end
	endgenerate

	// Comparator enabled in tamper detect mode only, at the chosen level; other blocks keep running
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			comparator_enable <= 1'b0;
			comparator_level <= 4'h0;
		end else begin
			comparator_enable <= (mode == tamper_detect_mode);
			comparator_level <= peak_detect_level;
		end
	end

	// Result pins, active low, valid once the window is over
	always_ff @(posedge core_clk) begin
		if (!reset_n || mode != tamper_detect_mode) begin
			interrupt_pin_zero_n <= 1'b1;
			interrupt_pin_one_n <= 1'b1;
		end else if (td_state_r == td_done) begin
			interrupt_pin_zero_n <= tamper_hit;
			interrupt_pin_one_n <= !tamper_hit;
		end
	end
endmodule : power_quality_monitor

/* File: logic/pq_monitor_cfg.svh */
`ifndef PQ_MONITOR_CFG_SVH
`define PQ_MONITOR_CFG_SVH
// Clock rates and the 512 kHz angle tick
`define CORE_CLK_HZ 40000000
`define ANGLE_TICK_HZ 512000
`define ANGLE_DIV ((`CORE_CLK_HZ + `ANGLE_TICK_HZ - 1) / `ANGLE_TICK_HZ)
// Tamper window: (N+4)/50 s, counted in 1/50 s line slots
`define LINE_SLOT_HZ 50
`define LINE_SLOT_CYCLES (`CORE_CLK_HZ / `LINE_SLOT_HZ)
`define LINE_BIAS 4'h4
`define LINE_MAX 4'hA
// Peak register layout
`define PEAK_SHIFT 5
`define PEAK_VAL_W 24
`define PEAK_PH_LSB 24
// Voltage connection codes
`define VCON_4W_A 3'h0
`define VCON_3W_A 3'h1
`define VCON_4W_B 3'h2
`define VCON_4W_C 3'h3
`define VCON_3W_B 3'h4
// Widths
`define ANGLE_W 16
`define SAMPLE_W 29
`endif

/* File: logic/pq_monitor_pkg.sv */
package pq_monitor_pkg;
	typedef enum logic [1:0] {
		normal_power_mode,
		tamper_measure_mode,
		tamper_detect_mode,
		idle_power_mode
	} power_mode_t;
	typedef enum logic [1:0] {
		td_idle,
		td_count,
		td_done
	} tamper_state_t;
endpackage : pq_monitor_pkg

/* File: tb/power_quality_monitor_sva.sv */
`timescale 1ns/10ps
`include "pq_monitor_cfg.svh"
// ****************************************
// Port checker for the monitor
// ****************************************
module pqm_checker (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [2:0] volt_pos,
	input wire logic [2:0] volt_neg,
	input wire logic [2:0] volt_above_threshold,
	input wire logic sample_strobe,
	input wire logic sequence_fault_clear,
	input wire logic sequence_irq_enable,
	input wire logic current_peak_read,
	input wire logic voltage_peak_read,
	input wire logic power_mode_pin_low,
	input wire logic power_mode_pin_high,
	input wire logic [`ANGLE_W-1:0] angle_volt_a_to_b,
	input wire logic sequence_fault_flag,
	input wire logic sequence_fault_irq_n,
	input wire logic [31:0] current_peak_capture,
	input wire logic [31:0] voltage_peak_capture,
	input wire logic comparator_enable,
	input wire logic interrupt_pin_zero_n,
	input wire logic interrupt_pin_one_n
);
	// One clock domain, so shared clocking and reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Sequence fault path
	// Irq follows the trip in the same cycle as the flag, and lags a clear by one
	property p_irq;
		sequence_fault_irq_n == !(($past(sequence_fault_flag) || sequence_fault_flag) && $past(sequence_irq_enable));
	endproperty
	a_irq: assert property (p_irq) else $error("irq out of step with flag");
	property p_sticky; sequence_fault_flag && !sequence_fault_clear |=> sequence_fault_flag; endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
	property p_trip; $rose(sequence_fault_flag) |-> $past(volt_pos) != 3'h0 || $past(volt_neg) != 3'h0; endproperty
	a_trip: assert property (p_trip) else $error("flag set without crossing");
	// Peak registers; a same-cycle sample may reload
	property p_ipk; current_peak_read && !sample_strobe |=> current_peak_capture == 32'h0000_0000; endproperty
	a_ipk: assert property (p_ipk) else $error("current peak kept after read");
	property p_vpk; voltage_peak_read && !sample_strobe |=> voltage_peak_capture == 32'h0000_0000; endproperty
	a_vpk: assert property (p_vpk) else $error("voltage peak kept after read");
	property p_upper; current_peak_capture[31:27] == 5'h00 && voltage_peak_capture[31:27] == 5'h00; endproperty
	a_upper: assert property (p_upper) else $error("peak spare bits set");
	// Angle only moves two cycles after a valid stop
	property p_hold;
		$changed(angle_volt_a_to_b) |-> $past(volt_pos[1], 2) && $past(volt_above_threshold[1], 2);
	endproperty
	a_hold: assert property (p_hold) else $error("angle moved without stop");
	// Tamper detection pins, allowing for the pin synchronisers
	property p_cmp; (power_mode_pin_high && !power_mode_pin_low) [*3] |-> ##[0:4] comparator_enable; endproperty
	a_cmp: assert property (p_cmp) else $error("comparator idle in tamper mode");
	property p_excl; !(!interrupt_pin_zero_n && !interrupt_pin_one_n); endproperty
	a_excl: assert property (p_excl) else $error("both tamper pins low");
	property p_quiet;
		(!power_mode_pin_high || power_mode_pin_low) [*4] |-> interrupt_pin_zero_n && interrupt_pin_one_n;
	endproperty
	a_quiet: assert property (p_quiet) else $error("tamper pin low outside mode");
endmodule : pqm_checker

bind power_quality_monitor pqm_checker i_chk (.*);

/* File: tb/host_pins_model.sv */
`timescale 1ns/10ps
// ****************************************
// Host side: mode pins and sequence count
// ****************************************
module host_pins_model
	import pq_monitor_pkg::*;
(
	input wire logic core_clk,
	input power_mode_t mode_req,
	input wire logic cfg_done,
	output logic power_mode_pin_low,
	output logic power_mode_pin_high,
	output logic [3:0] sequence_count
);
	// One observed sequence, as advised
	assign sequence_count = 4'h1;
	// Pins start in normal mode
	initial {power_mode_pin_high, power_mode_pin_low} = 2'b00;
	// Tamper entry refused until configured, else a stale setup runs
	always @(posedge core_clk) begin
		#2;
		if (mode_req != tamper_detect_mode || cfg_done) begin
			{power_mode_pin_high, power_mode_pin_low} <= mode_req;
		end
	end
endmodule : host_pins_model

/* File: tb/power_quality_monitor_tb.sv */
`timescale 1ns/10ps
`include "pq_monitor_cfg.svh"
module power_quality_monitor_tb;
	import pq_monitor_pkg::*;
	logic core_clk, reset_n, sample_strobe, seq_clr, irq_en, ipk_rd, vpk_rd, pm_lo, pm_hi, cfg_done;
	logic seq_flag, seq_irq_n, cmp_en, int0_n, int1_n;
	logic [2:0] volt_pos, volt_neg, above, cur_pos, cur_over, vcs, pps;
	logic [3:0] seq_cnt, lines, level, cmp_lvl;
	logic [`SAMPLE_W-1:0] cur_wave [3];
	logic [`SAMPLE_W-1:0] volt_wave [3];
	logic [`ANGLE_W-1:0] ang [9];
	logic [31:0] ipk, vpk;
	power_mode_t mode_req;
	int err_count, checks;
	// Short line slot keeps each tamper window to a few hundred cycles
	localparam int unsigned SLOT_TB = 100;
	// ****************************************
	// Clock, host model and device
	// ****************************************
	initial begin
		core_clk = 0;
		forever #12.5 core_clk = ~core_clk;
	end
	host_pins_model i_host (.core_clk(core_clk), .mode_req(mode_req), .cfg_done(cfg_done),
		.power_mode_pin_low(pm_lo), .power_mode_pin_high(pm_hi), .sequence_count(seq_cnt));
	power_quality_monitor #(.SLOT_CYCLES(SLOT_TB)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .volt_pos(volt_pos),
		.volt_neg(volt_neg), .volt_above_threshold(above), .cur_pos(cur_pos),
		.filtered_current_wave(cur_wave), .filtered_voltage_wave(volt_wave), .sample_strobe(sample_strobe),
		.cur_over_level(cur_over), .voltage_connection_select(vcs), .sequence_count(seq_cnt),
		.sequence_fault_clear(seq_clr), .sequence_irq_enable(irq_en), .peak_phase_select(pps),
		.current_peak_read(ipk_rd), .voltage_peak_read(vpk_rd), .detect_line_count(lines),
		.peak_detect_level(level), .power_mode_pin_low(pm_lo), .power_mode_pin_high(pm_hi),
		.angle_volt_a_to_b(ang[0]), .angle_volt_b_to_c(ang[1]), .angle_volt_a_to_c(ang[2]),
		.angle_cur_a_to_b(ang[3]), .angle_cur_b_to_c(ang[4]), .angle_cur_a_to_c(ang[5]),
		.angle_phase_a_v_to_i(ang[6]), .angle_phase_b_v_to_i(ang[7]), .angle_phase_c_v_to_i(ang[8]),
		.sequence_fault_flag(seq_flag), .sequence_fault_irq_n(seq_irq_n), .current_peak_capture(ipk),
		.voltage_peak_capture(vpk), .comparator_level(cmp_lvl), .comparator_enable(cmp_en),
		.interrupt_pin_zero_n(int0_n), .interrupt_pin_one_n(int1_n));
	// ****************************************
	// Shared tasks
	// ****************************************
	// Always land just after the edge, so inputs never race it
	task step(input int n);
		repeat (n) @(posedge core_clk);
		#2;
	endtask : step
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task end_of_test;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	task do_reset;
		reset_n = 0;
		step(20);
		reset_n = 1;
		step(1);
	endtask : do_reset
	// Events 0-2 rising volt, 3-5 falling volt, 6-8 current; idle cycle after
	task pulse(input int w);
		if (w < 3) volt_pos[w] = 1;
		else if (w < 6) volt_neg[w-3] = 1;
		else cur_pos[w-6] = 1;
		step(1);
		{volt_pos, volt_neg, cur_pos} = 9'h000;
		step(1);
	endtask : pulse
	// Tick phase is free running, so one count of slack
	task angle_case(input int a, input int b, input int k, input int idx);
		if (a >= 0) pulse(a);
		step(79 * k - 2);
		pulse(b);
		step(1);
		check(ang[idx] === 16'(k) || ang[idx] === 16'(k - 1), 1);
	endtask : angle_case
	task seq_case(input logic [2:0] vc, input int ev[$], input logic exp);
		do_reset();
		vcs = vc;
		step(1);
		foreach (ev[i]) pulse(ev[i]);
		step(1);
		check(seq_flag, exp);
		check(seq_irq_n, !exp);
	endtask : seq_case
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{volt_pos, volt_neg, cur_pos, cur_over, vcs, pps, lines, level} = 0;
		{sample_strobe, seq_clr, ipk_rd, vpk_rd, cfg_done} = 0;
		cur_wave = '{default: 0};
		volt_wave = '{default: 0};
		above = 3'h7;
		irq_en = 1;
		mode_req = normal_power_mode;
		do_reset();
		check(ipk, 32'h0000_0000);
		check({int0_n, int1_n, seq_irq_n}, 3'h7);
		angle_case(0, 1, 10, 0);
		angle_case(-1, 2, 4, 1);
		angle_case(0, 2, 20, 2);
		angle_case(6, 7, 7, 3);
		angle_case(2, 8, 5, 8);
		// Phase B below threshold: its stop is ignored and the old angle stands
		above[1] = 0;
		pulse(0);
		step(79 * 3 - 2);
		pulse(1);
		step(1);
		check(ang[0] === 16'd10 || ang[0] === 16'd9, 1);
		above[1] = 1;
		pulse(1);
		step(1);
		check(ang[0] === 16'd4 || ang[0] === 16'd3, 1);
		seq_case(3'h0, '{0, 1, 2, 0, 1, 2}, 0);
		for (int c = 2; c < 4; c++) seq_case(3'(c), '{0, 2}, 1);
		seq_case(3'h1, '{0, 2, 3, 5, 0}, 0);
		seq_case(3'h4, '{0, 3}, 1);
		seq_case(3'h1, '{0, 2, 3, 0}, 1);
		seq_case(3'h0, '{6, 7, 8}, 0);
		seq_case(3'h0, '{0, 1, 0}, 1);
		step(5);
		check(seq_flag, 1);
		seq_clr = 1;
		step(1);
		seq_clr = 0;
		step(2);
		check({seq_flag, seq_irq_n}, 2'b01);
		// Phase C is the largest but not selected
		pps = 3'h3;
		cur_wave = '{29'h0000_0400, 29'h0000_0400, 29'h0000_1000};
		volt_wave = '{29'h0000_0060, 29'h0000_0140, 29'h0000_0140};
		sample_strobe = 1;
		step(1);
		sample_strobe = 0;
		step(1);
		check(ipk, 32'h0300_0020);
		ipk_rd = 1;
		step(1);
		ipk_rd = 0;
		step(1);
		check(ipk, 32'h0000_0000);
		pps = 3'h7;
		vpk_rd = 1;
		sample_strobe = 1;
		step(1);
		{vpk_rd, sample_strobe} = 2'b00;
		step(1);
		check(vpk, 32'h0600_000a);
		vpk_rd = 1;
		step(1);
		vpk_rd = 0;
		step(1);
		check(vpk, 32'h0000_0000);
		// Tamper entry with N = 2: window of six line slots, three peaks needed
		lines = 4'h2;
		level = 4'h5;
		mode_req = tamper_detect_mode;
		step(8);
		check(cmp_en, 0);
		cfg_done = 1;
		step(8);
		check({cmp_en, cmp_lvl}, 5'h15);
		cur_over = 3'h1;
		step(4);
		cur_over = 3'h0;
		step(4);
		check({int0_n, int1_n}, 2'b11);
		// One peak only: pins stay high to just before the window end, then report clean
		step(SLOT_TB * 6 - 25);
		check({int0_n, int1_n}, 2'b11);
		step(20);
		check({int0_n, int1_n}, 2'b01);
		mode_req = idle_power_mode;
		step(8);
		check({int0_n, int1_n}, 2'b11);
		// Fresh window with three peaks on phase B: tamper
		mode_req = tamper_detect_mode;
		step(8);
		repeat (3) begin
			cur_over = 3'h2;
			step(3);
			cur_over = 3'h0;
			step(3);
		end
		step(SLOT_TB * 6);
		check({int0_n, int1_n}, 2'b10);
		mode_req = normal_power_mode;
		step(8);
		check({cmp_en, int0_n, int1_n}, 3'h3);
		end_of_test();
	end
	// Watchdog well past the expected run
	initial begin
		#1000000;
		err_count++;
		end_of_test();
	end
endmodule : power_quality_monitor_tb
